// file: rtl/timer_capture_output_control.sv
// 16-bit capture/compare timer channel with timer output control.
// Assumes a register master that follows the one-cycle strobe protocol.
`timescale 1ns/100ps
`include "timer_cc_defs.svh"
module timer_capture_output_control (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic resetn_i,
	// Register port.
	input wire timer_cc_pkg::bus_req_s bus_i,
	output logic [31:0] rdata_o,
	// Trigger pins.
	input wire logic trigger_a_i,
	input wire logic trigger_b_i,
	// Timer output and interrupt.
	output logic timer_output_pin_o,
	output logic irq_o
);
	import timer_cc_pkg::*;

	tcc_state_s s_q, s_d;
	op_mode_e op;
	logic running, tick, edge_a, edge_b, cap_trig_a;
	logic cap_a, cap_b, match_a, match_b, tog_a, tog_b, tog_e;
	logic ovf, wr_octl;
	logic [2:0] irq_set, irq_clr;

	// Edge detectors for the two trigger pins.
	trigger_edge u_edge_a (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.pin_i(trigger_a_i),
		.sel_i(edge_sel_e'(s_q.mode[`TCC_MODE_ESA_LSB +: 2])),
		.edge_o(edge_a)
	);

	trigger_edge u_edge_b (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.pin_i(trigger_b_i),
		.sel_i(edge_sel_e'(s_q.mode[`TCC_MODE_ESB_LSB +: 2])),
		.edge_o(edge_b)
	);

	// Event decode from the present state.
	always_comb begin
		op = op_mode_e'(s_q.mode[`TCC_MODE_OP_LSB +: 2]);
		running = (op != OP_STOP);
		// The divider runs free, so the first count after a start lands
		// anywhere within one count clock.
		tick = running && (s_q.div == `TCC_CNT_DIV - 8'h01);
		cap_trig_a = s_q.mode[`TCC_MODE_SELA] ? edge_a : edge_b;
		cap_a = running && s_q.mode[`TCC_MODE_CAPA] && cap_trig_a;
		cap_b = running && s_q.mode[`TCC_MODE_CAPB] && edge_a;
		match_a = tick && !s_q.mode[`TCC_MODE_CAPA] &&
			(s_q.counter == s_q.cca);
		match_b = tick && !s_q.mode[`TCC_MODE_CAPB] &&
			(s_q.counter == s_q.ccb);
		tog_a = match_a && s_q.octl[`TCC_OCTL_INVA];
		tog_b = match_b && s_q.octl[`TCC_OCTL_INVB];
		// Only useful when the output is not on the trigger A pin.
		tog_e = running && s_q.mode[`TCC_MODE_EDGE_INV] && edge_a;
		ovf = tick && (s_q.counter == `TCC_COUNT_MAX);
		wr_octl = bus_i.wr && (bus_i.addr == `TCC_OFF_OCTL);
		irq_set = 3'h0;
		irq_set[`TCC_IRQ_A] = match_a | cap_a;
		irq_set[`TCC_IRQ_B] = match_b | cap_b;
		irq_set[`TCC_IRQ_OVF] = ovf;
		irq_clr = 3'h0;
		if (bus_i.wr && bus_i.addr == `TCC_OFF_STATUS) begin
			irq_clr = bus_i.wdata[2:0];
		end
	end

	// Next state: bus writes, counter, captures, pin and interrupt.
	always_comb begin
		s_d = s_q;
		if (s_q.div == `TCC_CNT_DIV - 8'h01) begin
			s_d.div = 8'h00;
		end else begin
			s_d.div = s_q.div + 8'h01;
		end

		// Register writes; a capture in the same cycle beats software.
		if (bus_i.wr) begin
			case (bus_i.addr)
				`TCC_OFF_MODE: s_d.mode = bus_i.wdata[9:0];
				`TCC_OFF_OCTL: s_d.octl = bus_i.wdata[3:0];
				`TCC_OFF_CCA: s_d.cca = bus_i.wdata[15:0];
				`TCC_OFF_CCB: s_d.ccb = bus_i.wdata[15:0];
				`TCC_OFF_MASK: s_d.mask = bus_i.wdata[2:0];
				default: s_d.mask = s_q.mask;
			endcase
		end
		// A read never blocks a capture; only the read value suffers.
		if (cap_a) begin
			s_d.cca = s_q.counter;
		end
		if (cap_b) begin
			s_d.ccb = s_q.counter;
		end

		// Counter: held at zero while stopped, so a start counts from zero.
		if (!running) begin
			s_d.counter = 16'h0000;
		end else if (op == OP_CLR_EDGE && edge_a) begin
			s_d.counter = 16'h0000;
		end else if (tick) begin
			if (op == OP_CLR_MATCH && s_q.counter == s_q.cca) begin
				s_d.counter = 16'h0000;
			end else begin
				s_d.counter = s_q.counter + 16'h0001;
			end
		end

		// Output pin: software levels while stopped, toggles while running.
		if (!running) begin
			if (wr_octl) begin
				case ({bus_i.wdata[`TCC_OCTL_LVS], bus_i.wdata[`TCC_OCTL_LVR]})
					2'h2: s_d.pin = 1'b1;
					2'h1: s_d.pin = 1'b0;
					default: s_d.pin = s_q.pin;
				endcase
			end
		end else begin
			// The preset level is the starting point of the toggles.
			s_d.pin = s_q.pin ^ tog_a ^ tog_b ^ tog_e;
		end

		// Sticky status: a new event wins over a clear in the same cycle.
		s_d.status = (s_q.status & ~irq_clr) | irq_set;
		s_d.irq = |(s_d.status & ~s_d.mask);

		// Read data stand only in the cycle after the read strobe.
		s_d.rdata = 32'h0000_0000;
		if (bus_i.rd) begin
			case (bus_i.addr)
				`TCC_OFF_MODE: s_d.rdata = {22'h000000, s_q.mode};
				`TCC_OFF_OCTL: s_d.rdata = {28'h0000000, s_q.octl};
				`TCC_OFF_COUNT: s_d.rdata = {16'h0000, s_q.counter};
				`TCC_OFF_CCA: s_d.rdata = {16'h0000, s_q.cca};
				`TCC_OFF_CCB: s_d.rdata = {16'h0000, s_q.ccb};
				`TCC_OFF_STATUS: s_d.rdata = {29'h00000000, s_q.status};
				`TCC_OFF_MASK: s_d.rdata = {29'h00000000, s_q.mask};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q.mode <= `TCC_RST_MODE;
			s_q.octl <= `TCC_RST_OCTL;
			s_q.counter <= 16'h0000;
			s_q.cca <= `TCC_RST_CC;
			s_q.ccb <= `TCC_RST_CC;
			s_q.status <= 3'h0;
			s_q.mask <= `TCC_RST_MASK;
			s_q.div <= 8'h00;
			s_q.pin <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output is a flip-flop.
	assign rdata_o = s_q.rdata;
	assign timer_output_pin_o = s_q.pin;
	assign irq_o = s_q.irq;

	// Checks of the documented behaviour.
	sequence s_stopped_start;
		!running ##0 (bus_i.wr && bus_i.addr == `TCC_OFF_MODE &&
			bus_i.wdata[1:0] != 2'h0);
	endsequence

	sequence s_force_high;
		!running ##0 wr_octl ##0
			(bus_i.wdata[`TCC_OCTL_LVS +: 1] == 1'b1) ##0
			(bus_i.wdata[`TCC_OCTL_LVR +: 1] == 1'b0);
	endsequence

	sequence s_force_low;
		!running ##0 wr_octl ##0
			(bus_i.wdata[`TCC_OCTL_LVS +: 1] == 1'b0) ##0
			(bus_i.wdata[`TCC_OCTL_LVR +: 1] == 1'b1);
	endsequence

	AST_CAPTURE_B: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		cap_b |=> s_q.ccb == $past(s_q.counter))
		else $error("Trigger A edge did not capture counter into B.");

	AST_B_MATCH_GATED: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(match_b && !s_q.octl[`TCC_OCTL_INVB] && !tog_a && !tog_e)
		|=> $stable(s_q.pin))
		else $error("B match moved the pin while inversion was off.");

	AST_B_MATCH_TOGGLE: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(tog_b && !tog_a && !tog_e) |=> s_q.pin != $past(s_q.pin))
		else $error("Enabled B match did not invert the pin.");

	AST_FORCE_HIGH: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		s_force_high |=> s_q.pin ##1 (s_q.pin || running || $past(wr_octl)))
		else $error("Level pair 10 did not drive the pin high.");

	AST_FORCE_LOW: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		s_force_low |=> !s_q.pin)
		else $error("Level pair 01 did not drive the pin low.");

	AST_LEVEL_HOLD: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(!running && !wr_octl) |=> $stable(s_q.pin))
		else $error("Pin moved while stopped without a level write.");

	AST_START_LEVEL: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		s_stopped_start |=> (s_q.pin == $past(s_q.pin)) &&
			(s_q.counter == 16'h0000) && running)
		else $error("Start did not keep the preset level.");

	AST_A_MATCH_TOGGLE: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(tog_a && !tog_b && !tog_e) |=>
			(s_q.pin != $past(s_q.pin)) && s_q.status[`TCC_IRQ_A])
		else $error("A match did not invert the pin and raise A.");

	AST_FIRST_TICK: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		s_stopped_start ##1 (running && !edge_a)[*5] |->
			s_q.counter != 16'h0000)
		else $error("Counter did not step within one count clock.");

	AST_CAPTURE_IRQ: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(cap_b && bus_i.rd) |=> s_q.status[`TCC_IRQ_B] &&
			s_q.ccb == $past(s_q.counter))
		else $error("Capture during a read was lost.");

	AST_EDGE_CLEAR: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(op == OP_CLR_EDGE && edge_a && !(bus_i.wr &&
			bus_i.addr == `TCC_OFF_MODE)) |=> s_q.counter == 16'h0000)
		else $error("Trigger A edge did not clear the counter.");

	AST_CAPTURE_A: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		cap_a |=> s_q.cca == $past(s_q.counter) &&
			s_q.status[`TCC_IRQ_A])
		else $error("Selected trigger did not capture into A.");

	AST_MATCH_CLEAR: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		(op == OP_CLR_MATCH && tick && s_q.counter == s_q.cca &&
			!bus_i.wr) |=> s_q.counter == 16'h0000)
		else $error("A match did not clear the counter in mode 11.");

	AST_IRQ_LEVEL: assert property (
		@(posedge clock_i) disable iff (!resetn_i)
		##1 irq_o == |(s_q.status & ~s_q.mask))
		else $error("Interrupt output disagrees with status and mask.");

endmodule // timer_capture_output_control

// file: rtl/trigger_edge.sv
// Synchroniser and valid-edge detector for one trigger pin.
// Assumes an asynchronous pin; the edge pulse lasts one main clock.
`timescale 1ns/100ps
module trigger_edge (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic resetn_i,
	// Pin and selection.
	input wire logic pin_i,
	input wire timer_cc_pkg::edge_sel_e sel_i,
	// Detected edge.
	output logic edge_o
);
	import timer_cc_pkg::*;

	edge_state_s s_q, s_d;

	// Two stages catch the pin; only the second one feeds the detector.
	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin_i;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		case (sel_i)
			EDGE_FALL: edge_o = s_q.prev & ~s_q.sync2;
			EDGE_RISE: edge_o = ~s_q.prev & s_q.sync2;
			EDGE_BOTH: edge_o = s_q.prev ^ s_q.sync2;
			default: edge_o = 1'b0;
		endcase
	end

	// A pin already high at reset release is seen as a rising edge.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // trigger_edge

// file: shared/timer_cc_defs.svh
// Constants of the capture/compare timer channel: offsets, fields, resets.
// Assumes inclusion by bare name from files that need the numbers.
`ifndef TIMER_CC_DEFS_SVH
`define TIMER_CC_DEFS_SVH

// Register byte offsets on the plain register port.
`define TCC_OFF_MODE 8'h00
`define TCC_OFF_OCTL 8'h04
`define TCC_OFF_COUNT 8'h08
`define TCC_OFF_CCA 8'h0C
`define TCC_OFF_CCB 8'h10
`define TCC_OFF_STATUS 8'h14
`define TCC_OFF_MASK 8'h18

// Mode control register fields.
`define TCC_MODE_OP_LSB 0
`define TCC_MODE_CAPA 2
`define TCC_MODE_CAPB 3
`define TCC_MODE_SELA 4
`define TCC_MODE_EDGE_INV 5
`define TCC_MODE_ESA_LSB 6
`define TCC_MODE_ESB_LSB 8

// Output control register fields.
`define TCC_OCTL_INVA 0
`define TCC_OCTL_LVR 1
`define TCC_OCTL_LVS 2
`define TCC_OCTL_INVB 3

// Interrupt status and mask fields.
`define TCC_IRQ_A 0
`define TCC_IRQ_B 1
`define TCC_IRQ_OVF 2

// Reset values and the top count.
`define TCC_RST_MODE 10'h000
`define TCC_RST_OCTL 4'h0
`define TCC_RST_CC 16'h0000
`define TCC_RST_MASK 3'h7
`define TCC_COUNT_MAX 16'hFFFF

// Main clocks per count clock.
`define TCC_CNT_DIV 8'h04

`endif

// file: shared/timer_cc_pkg.sv
// Types shared by the timer channel: bus request, modes and state records.
// Assumes the constants header is compiled alongside.
package timer_cc_pkg;

	// One request on the plain register port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_s;

	// Operating mode of the counter.
	typedef enum logic [1:0] {
		OP_STOP = 2'h0,
		OP_FREE = 2'h1,
		OP_CLR_EDGE = 2'h2,
		OP_CLR_MATCH = 2'h3
	} op_mode_e;

	// Edge selection of a trigger input.
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_NONE = 2'h3
	} edge_sel_e;

	// State of the edge detector.
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
	} edge_state_s;

	// State of the timer channel.
	typedef struct packed {
		logic [9:0] mode;
		logic [3:0] octl;
		logic [15:0] counter;
		logic [15:0] cca;
		logic [15:0] ccb;
		logic [2:0] status;
		logic [2:0] mask;
		logic [7:0] div;
		logic pin;
		logic irq;
		logic [31:0] rdata;
	} tcc_state_s;

endpackage

// file: verif/timer_capture_output_control_tb.sv
// Self-checking bench of the timer channel driven over its register port.
// Assumes the package, header, design and trigger model compiled before.
`timescale 1ns/100ps
`include "timer_cc_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module timer_capture_output_control_tb;
	import timer_cc_pkg::*;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	bus_req_s bus = '0;
	logic [31:0] rdata_o;
	logic trg_a;
	logic trg_b;
	logic pin;
	logic irq;
	logic fire_a = 1'b0;
	logic fire_b = 1'b0;
	logic [31:0] v;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int ts, t0, t1, t2;
	logic [7:0] offs [7] = '{`TCC_OFF_MODE, `TCC_OFF_OCTL, `TCC_OFF_CCA,
		`TCC_OFF_CCB, `TCC_OFF_STATUS, `TCC_OFF_MASK, 8'h1C};
	logic [31:0] exps [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0};
	logic [31:0] lvl [7] = '{32'h4, 32'h0, 32'h2, 32'h0, 32'h4, 32'h5, 32'h2};
	logic [6:0] lexp = 7'h33;

	// Main clock and a cycle count for timing checks.
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;

	timer_capture_output_control i_timer_capture_output_control (
		.clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus),
		.rdata_o(rdata_o), .trigger_a_i(trg_a), .trigger_b_i(trg_b),
		.timer_output_pin_o(pin), .irq_o(irq));
	trigger_source i_trigger_source (.clock_i(clock_i), .resetn_i(resetn_i),
		.fire_a_i(fire_a), .fire_b_i(fire_b), .trigger_a_o(trg_a),
		.trigger_b_o(trg_b));

	// One write cycle on the register port.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock_i);
		bus.wr <= 1'b0;
	endtask

	// One read cycle; the data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clock_i);
		bus.rd <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic cr(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		`CHK("register", e, v)
	endtask

	// Waits for the output pin to change, bounded so a stuck pin is caught.
	task automatic wp(output int t);
		logic p;
		int n;
		#1 p = pin;
		n = 0;
		while (pin === p && n < 200) begin
			@(posedge clock_i);
			#1 n++;
		end
		t = cyc;
		`CHK("pin change", 1'b1, n < 200)
	endtask

	// Pulses one trigger, reads the target during the capture, then checks
	// the captured value against the elapsed count clocks since start.
	task automatic cap(input logic sel_b, input logic [7:0] a);
		int k;
		@(posedge clock_i);
		k = cyc - ts;
		fire_a <= ~sel_b;
		fire_b <= sel_b;
		@(posedge clock_i);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
		// The first read strobe lands on the very edge of the capture.
		@(posedge clock_i);
		repeat (7) rd(a, v);
		`CHK("capture", 1'b1, v >= (k - 4) / 4 && v <= (k + 8) / 4)
	endtask

	task automatic test_done;
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog far beyond the few hundred cycles the tests need.
	initial begin
		#100000;
		err_total++;
		test_done;
	end

	initial begin
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		foreach (offs[i]) cr(offs[i], exps[i]);
		foreach (lvl[i]) begin
			wr(`TCC_OFF_OCTL, lvl[i]);
			@(posedge clock_i);
			#1 `CHK("pin level", lexp[i], pin)
		end
		// Preset high, invert on A match only, then start in match-clear mode.
		wr(`TCC_OFF_OCTL, 32'h4);
		wr(`TCC_OFF_OCTL, 32'h1);
		wr(`TCC_OFF_CCA, 32'h3);
		wr(`TCC_OFF_CCB, 32'h1);
		wr(`TCC_OFF_MASK, 32'h6);
		wr(`TCC_OFF_MODE, 32'h3);
		ts = cyc;
		@(posedge clock_i);
		#1 `CHK("start level", 1'b1, pin)
		wp(t0);
		`CHK("first match", 1'b1, t0 - ts >= 12 && t0 - ts <= 20)
		wp(t1);
		`CHK("period", 16, t1 - t0)
		`CHK("irq a", 1'b1, irq)
		// Duty change of register B right after a match, in the safe order.
		wp(t0);
		// Let the B match at count 1 pass before touching register B.
		repeat (8) @(posedge clock_i);
		wr(`TCC_OFF_MASK, 32'h7);
		wr(`TCC_OFF_OCTL, 32'h1);
		wr(`TCC_OFF_CCB, 32'h2);
		repeat (4) @(posedge clock_i);
		wr(`TCC_OFF_OCTL, 32'h9);
		wr(`TCC_OFF_STATUS, 32'h2);
		wr(`TCC_OFF_MASK, 32'h4);
		wp(t0);
		wp(t1);
		wp(t2);
		`CHK("duty sum", 16, t2 - t0)
		`CHK("duty split", 48, (t1 - t0) * (t2 - t1))
		rd(`TCC_OFF_STATUS, v);
		`CHK("status ab", 2'h3, v[1:0])
		`CHK("irq on", 1'b1, irq)
		wr(`TCC_OFF_MASK, 32'h7);
		repeat (2) @(posedge clock_i);
		#1 `CHK("irq masked", 1'b0, irq)
		wr(`TCC_OFF_MODE, 32'h0);
		wr(`TCC_OFF_STATUS, 32'h7);
		cr(`TCC_OFF_STATUS, 32'h0);
		// Free running, both registers capture on rising edges.
		wr(`TCC_OFF_MODE, 32'h14D);
		ts = cyc;
		repeat (40) @(posedge clock_i);
		cap(1'b0, `TCC_OFF_CCB);
		cap(1'b1, `TCC_OFF_CCA);
		rd(`TCC_OFF_STATUS, v);
		`CHK("capture flags", 2'h3, v[1:0])
		// Clear and restart on a trigger A edge.
		wr(`TCC_OFF_MODE, 32'h0);
		wr(`TCC_OFF_MODE, 32'h14E);
		ts = cyc;
		repeat (60) @(posedge clock_i);
		cap(1'b0, `TCC_OFF_CCB);
		rd(`TCC_OFF_COUNT, v);
		`CHK("cleared", 1'b1, v < 32'h6)
		// Both edges of trigger A invert the pin and capture into A.
		wr(`TCC_OFF_MODE, 32'h0);
		wr(`TCC_OFF_OCTL, 32'h0);
		wr(`TCC_OFF_STATUS, 32'h7);
		wr(`TCC_OFF_MODE, 32'h3B5);
		@(posedge clock_i);
		fire_a <= 1'b1;
		@(posedge clock_i);
		fire_a <= 1'b0;
		wp(t0);
		wp(t1);
		`CHK("edge toggles", 12, t1 - t0)
		rd(`TCC_OFF_STATUS, v);
		`CHK("capture a flag", 2'h1, v[1:0])
		test_done;
	end
endmodule // timer_capture_output_control_tb

// file: verif/trigger_source.sv
// Model of the two external trigger sources wired to the channel's pins.
// Assumes one-cycle fire commands from the bench on the main clock.
`timescale 1ns/100ps
module trigger_source #(
	parameter int WIDTH = 12
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic resetn_i,
	// Commands from the bench.
	input wire logic fire_a_i,
	input wire logic fire_b_i,
	// Trigger pins, pulled low when idle.
	output logic trigger_a_o,
	output logic trigger_b_o
);
	int cnt_a;
	int cnt_b;

	// Each fire makes one high pulse, kept wider than two count clocks.
	// The pins are sampled on every main clock, so a pulse of one main clock is still captured.
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_a <= 0;
			cnt_b <= 0;
		end else begin
			cnt_a <= fire_a_i ? WIDTH : (cnt_a > 0 ? cnt_a - 1 : 0);
			cnt_b <= fire_b_i ? WIDTH : (cnt_b > 0 ? cnt_b - 1 : 0);
		end
	end

	// The pins are high only while a pulse is running.
	assign trigger_a_o = cnt_a > 0;
	assign trigger_b_o = cnt_b > 0;
endmodule // trigger_source
